/* File: logic/sss_blinker.sv */
`timescale 1ns/100ps
module sss_blinker
   import sss_pkg::*;
#(
   parameter int unsigned HALF_CYC = HALF_PERIOD_CYC
) (
   input  wire logic clock_in,
   input  wire logic reset_n_in,
   output logic      phase_out
);
   logic [31:0] cnt_r;

   // equal on and off halves of one period
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_r     <= 32'h0000_0000;
         phase_out <= 1'b0;
      end else if (cnt_r >= HALF_CYC - 1) begin
         cnt_r     <= 32'h0000_0000;
         phase_out <= ~phase_out;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end
endmodule

/* File: logic/sss_pkg.sv */
package sss_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned BLINK_PERIOD_MS = 1000;
   localparam int unsigned HALF_PERIOD_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
   localparam int unsigned ADDR_W          = 8;
   localparam int unsigned NUM_CH          = 16;
   localparam int unsigned SAMPLE_W        = 16;
   localparam int unsigned CH_IDX_W        = 4;
   localparam int unsigned DIAG_W          = 4;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 16'h0000;

   typedef enum logic [2:0] {
      SSS_POWERUP  = 3'b000,
      SSS_UNCONFIG = 3'b001,
      SSS_INIT     = 3'b011,
      SSS_RUN      = 3'b010,
      SSS_IDLE_LNK = 3'b110,
      SSS_FATAL    = 3'b111
   } sss_state_t;
endpackage

/* File: logic/sss_top.sv */
`timescale 1ns/100ps
module sss_top
   import sss_pkg::*;
#(
   parameter int unsigned HALF_CYC = HALF_PERIOD_CYC
) (
   input  wire logic                CLOCK_IN,
   input  wire logic                RESET_N_IN,
   input  wire logic [ADDR_W-1:0]   ADDR_SWITCH_IN,
   input  wire logic [ADDR_W-1:0]   BUS_ADDR_IN,
   input  wire logic                BUS_SEL_IN,
   input  wire logic                CFG_IRQ_IN,
   input  wire logic                MASTER_EXEC_IN,
   input  wire logic                LINK_OK_IN,
   input  wire logic                DIAG_DONE_IN,
   input  wire logic                DIAG_PASS_IN,
   input  wire logic                FATAL_FAIL_IN,
   input  wire logic                POWER_FAIL_INTERRUPT_IN,
   input  wire logic                DIAG_MODE_IN,
   input  wire logic                DIAG_RESULT_IN,
   input  wire logic                SAMPLE_VALID_IN,
   input  wire logic [CH_IDX_W-1:0] SAMPLE_CH_IN,
   input  wire logic [SAMPLE_W-1:0] SAMPLE_DATA_IN,
   input  wire logic [CH_IDX_W-1:0] READ_CH_IN,
   output logic                     SELECTED_OUT,
   output logic [SAMPLE_W-1:0]      READ_DATA_OUT,
   output logic                     READ_GOOD_OUT,
   output logic                     SCAN_ENABLE_OUT,
   output logic                     REINIT_OUT,
   output logic                     LED_RED_OUT,
   output logic                     LED_GREEN_OUT
);
   // every pin input except the sample and read-channel inputs synchronised through two flops
   localparam int unsigned SYNC_W = 2 * ADDR_W + 10;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [ADDR_W-1:0] sw_s;
   logic [ADDR_W-1:0] badr_s;
   logic              sel_s;
   logic              irq_s;
   logic              exec_s;
   logic              link_s;
   logic              ddone_s;
   logic              dpass_s;
   logic              fatal_s;
   logic              pfi_s;
   logic              dmode_s;
   logic              dres_s;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {ADDR_SWITCH_IN, BUS_ADDR_IN, BUS_SEL_IN, CFG_IRQ_IN, MASTER_EXEC_IN,
                     LINK_OK_IN, DIAG_DONE_IN, DIAG_PASS_IN, FATAL_FAIL_IN,
                     POWER_FAIL_INTERRUPT_IN, DIAG_MODE_IN, DIAG_RESULT_IN};
         sync2_r <= sync1_r;
      end
   end

   assign {sw_s, badr_s, sel_s, irq_s, exec_s, link_s, ddone_s, dpass_s, fatal_s,
           pfi_s, dmode_s, dres_s} = sync2_r;

   // address match
   assign SELECTED_OUT = sel_s && (badr_s == sw_s);

   // configuration interrupt edge
   logic irq_d_r;
   logic irq_rise;
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         irq_d_r <= 1'b0;
      end else begin
         irq_d_r <= irq_s;
      end
   end
   assign irq_rise = irq_s && !irq_d_r && SELECTED_OUT;

   // master execute to configure transition
   logic exec_d_r;
   logic cfg_mode_r;
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         exec_d_r   <= 1'b0;
         cfg_mode_r <= 1'b0;
      end else begin
         exec_d_r <= exec_s;
         if (exec_d_r && !exec_s) begin
            cfg_mode_r <= 1'b1;
         end else if (exec_s) begin
            cfg_mode_r <= 1'b0;
         end
      end
   end

   // sequencer
   sss_state_t state_r;
   sss_state_t state_nxt;
   logic       red_latch_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SSS_POWERUP: begin
            if (ddone_s) begin
               state_nxt = dpass_s ? SSS_UNCONFIG : SSS_FATAL;
            end
         end
         SSS_UNCONFIG: begin
            if (irq_rise) begin
               state_nxt = SSS_INIT;
            end
         end
         SSS_INIT: begin
            state_nxt = SSS_RUN;
         end
         SSS_RUN: begin
            if (irq_rise) begin
               state_nxt = SSS_INIT;
            end else if (!link_s) begin
               state_nxt = SSS_IDLE_LNK;
            end
         end
         SSS_IDLE_LNK: begin
            if (irq_rise) begin
               state_nxt = SSS_INIT;
            end else if (link_s) begin
               state_nxt = SSS_RUN;
            end
         end
         SSS_FATAL: begin
            state_nxt = SSS_FATAL;
         end
         default: begin
            state_nxt = SSS_FATAL;
         end
      endcase
      if (fatal_s) begin
         state_nxt = SSS_FATAL;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_r <= SSS_POWERUP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // sticky red: power fail or fatal never clears without reset
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         red_latch_r <= 1'b0;
      end else if (pfi_s || state_nxt == SSS_FATAL) begin
         red_latch_r <= 1'b1;
      end
   end

   assign REINIT_OUT      = (state_r == SSS_INIT);
   assign SCAN_ENABLE_OUT = (state_r == SSS_RUN || state_r == SSS_IDLE_LNK)
                            && !red_latch_r;

   // per-channel published value and quality
   logic [SAMPLE_W-1:0] value_r [NUM_CH];
   logic [NUM_CH-1:0]   good_r;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
         if (!RESET_N_IN) begin
            value_r[g] <= SAMPLE_RESET;
            good_r[g]  <= 1'b0;
         end else if (REINIT_OUT) begin
            good_r[g]  <= 1'b0;
         end else if (SCAN_ENABLE_OUT && SAMPLE_VALID_IN
                      && SAMPLE_CH_IN == CH_IDX_W'(g)) begin
            value_r[g] <= SAMPLE_DATA_IN;
            good_r[g]  <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         READ_DATA_OUT <= SAMPLE_RESET;
         READ_GOOD_OUT <= 1'b0;
      end else begin
         READ_DATA_OUT <= value_r[READ_CH_IN];
         READ_GOOD_OUT <= good_r[READ_CH_IN];
      end
   end

   // indicator
   logic blink;
   sss_blinker #(
      .HALF_CYC (HALF_CYC)
   ) u_blink (
      .clock_in   (CLOCK_IN),
      .reset_n_in (RESET_N_IN),
      .phase_out  (blink)
   );

   logic red_nxt;
   logic green_nxt;
   always_comb begin
      red_nxt   = 1'b0;
      green_nxt = 1'b0;
      if (red_latch_r) begin
         red_nxt = 1'b1;
      end else if (dmode_s) begin
         red_nxt   = !dres_s;
         green_nxt = dres_s;
      end else begin
         unique case (state_r)
            SSS_POWERUP:  red_nxt   = blink;
            SSS_UNCONFIG: green_nxt = 1'b0;
            SSS_INIT:     green_nxt = 1'b1;
            SSS_RUN:      green_nxt = cfg_mode_r ? blink : 1'b1;
            SSS_IDLE_LNK: green_nxt = blink;
            SSS_FATAL:    red_nxt   = 1'b1;
            default:      red_nxt   = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         LED_RED_OUT   <= 1'b0;
         LED_GREEN_OUT <= 1'b0;
      end else begin
         LED_RED_OUT   <= red_nxt;
         LED_GREEN_OUT <= green_nxt;
      end
   end
endmodule

/* File: test/slave_status_sequencer_tb_top.sv */
`timescale 1ns/100ps
module slave_status_sequencer_tb_top;
   import sss_pkg::*;
   logic                clk = 0, rst_n = 0, dg_done = 0, dg_pass = 0, fatal = 0, power_fail_interrupt = 0;
   logic                dmode = 0, dres = 0, s_valid = 0;
   logic [CH_IDX_W-1:0] s_ch = '0, r_ch = '0;
   logic [SAMPLE_W-1:0] s_data = '0, rdata;
   logic [ADDR_W-1:0]   b_addr, sw = 8'h05;
   logic                sel, irq, exec, link, selected, good, scan, reinit, red, green;
   int                  n_mismatch = 0, n_checks = 0, n_reinit = 0, n_sel = 0, r_hi, g_hi, k;
   sss_master_model u_sss_master_model (.clock_in(clk), .bus_addr_out(b_addr),
      .bus_sel_out(sel), .cfg_irq_out(irq), .exec_out(exec), .link_ok_out(link));
   sss_top #(.HALF_CYC(4)) u_sss_top (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
      .ADDR_SWITCH_IN(sw), .BUS_ADDR_IN(b_addr), .BUS_SEL_IN(sel), .CFG_IRQ_IN(irq),
      .MASTER_EXEC_IN(exec), .LINK_OK_IN(link), .DIAG_DONE_IN(dg_done), .DIAG_PASS_IN(dg_pass),
      .FATAL_FAIL_IN(fatal), .POWER_FAIL_INTERRUPT_IN(power_fail_interrupt), .DIAG_MODE_IN(dmode),
      .DIAG_RESULT_IN(dres), .SAMPLE_VALID_IN(s_valid), .SAMPLE_CH_IN(s_ch),
      .SAMPLE_DATA_IN(s_data), .READ_CH_IN(r_ch), .SELECTED_OUT(selected),
      .READ_DATA_OUT(rdata), .READ_GOOD_OUT(good), .SCAN_ENABLE_OUT(scan),
      .REINIT_OUT(reinit), .LED_RED_OUT(red), .LED_GREEN_OUT(green));
   initial begin
      forever #5 clk = ~clk;
   end
   // counted mid-cycle, away from the edge that launches them
   always @(negedge clk) begin
      n_reinit += (reinit === 1'b1);
      n_sel    += (selected === 1'b1);
   end
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask
   task automatic watch(input int n);
      r_hi = 0;
      g_hi = 0;
      repeat (n) begin
         @(posedge clk) #1;
         r_hi += (red === 1'b1);
         g_hi += (green === 1'b1);
      end
   endtask
   task automatic sample(input logic [3:0] c, input logic [15:0] d);
      @(posedge clk) #1;
      {s_ch, s_data, s_valid, r_ch} = {c, d, 1'b1, c};
      @(posedge clk) #1;
      s_valid = 1'b0;
      repeat (3) @(posedge clk) #1;
   endtask
   task automatic t_start;
      watch(16);
      chk(r_hi > 0 && r_hi < 16 && g_hi == 0, "no red flash at power-up");
      {dg_done, dg_pass} = 2'b11;
      watch(8);
      watch(16);
      chk(r_hi == 0 && g_hi == 0, "not dark before config");
      sample(4'h3, 16'h1234);
      chk(good === 1'b0, "good before config");
      $display("done start");
   endtask
   task automatic t_config;
      u_sss_master_model.send_cfg(8'h06);
      chk(n_reinit == 0 && n_sel == 0, "answered foreign address");
      u_sss_master_model.send_cfg(8'h05);
      chk(n_reinit == 1 && n_sel > 0, "no reinit on interrupt");
      watch(16);
      chk(g_hi == 16 && r_hi == 0 && scan === 1'b1, "not steady green");
      chk(good === 1'b0, "good before sample");
      sample(4'h3, 16'h1234);
      chk(good === 1'b1 && rdata === 16'h1234, "scanned value lost");
      r_ch = 4'h4;
      @(posedge clk) #1;
      @(posedge clk) #1;
      chk(good === 1'b0, "unsampled channel good");
      sw = 8'h09;
      k  = n_sel;
      u_sss_master_model.send_cfg(8'h05);
      chk(n_reinit == 1 && n_sel == k, "old address still answered");
      u_sss_master_model.send_cfg(8'h09);
      chk(n_reinit == 2, "moved switch not answered");
      $display("done config");
   endtask
   task automatic t_modes;
      logic [1:0] p;
      {dmode, dres} = 2'b11;
      watch(8);
      p = {red, green};
      dres = 1'b0;
      watch(8);
      chk(p === 2'b01 && {red, green} === 2'b10, "diag result not shown");
      dmode = 1'b0;
      u_sss_master_model.set_mode(1'b0, 1'b1);
      watch(24);
      chk(g_hi > 0 && g_hi < 24, "no blink in configure mode");
      u_sss_master_model.set_mode(1'b1, 1'b0);
      watch(24);
      chk(g_hi > 0 && g_hi < 24, "no blink on link loss");
      u_sss_master_model.set_mode(1'b1, 1'b1);
      u_sss_master_model.send_cfg(8'h09);
      r_ch = 4'h3;
      watch(16);
      chk(g_hi == 16 && good === 1'b0, "reconfig not clean");
      $display("done modes");
   endtask
   task automatic pulse_reset;
      rst_n = 1'b0;
      repeat (5) @(posedge clk) #1;
      rst_n = 1'b1;
   endtask
   task automatic t_red;
      power_fail_interrupt = 1'b1;
      repeat (2) @(posedge clk) #1;
      power_fail_interrupt = 1'b0;
      watch(6);
      watch(16);
      chk(r_hi == 16 && g_hi == 0 && scan === 1'b0, "power fail not red");
      dg_pass = 1'b0;
      pulse_reset();
      watch(6);
      watch(16);
      chk(r_hi == 16 && g_hi == 0, "failed diagnostics not red");
      dg_pass = 1'b1;
      pulse_reset();
      fatal = 1'b1;
      repeat (2) @(posedge clk) #1;
      fatal = 1'b0;
      k = n_reinit;
      u_sss_master_model.send_cfg(8'h09);
      watch(16);
      chk(r_hi == 16 && n_reinit == k, "fatal not latched red");
      $display("done red");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clk) #1;
      rst_n = 1'b1;
      t_start();
      t_config();
      t_modes();
      t_red();
      report_and_stop();
   end
endmodule

/* File: test/sss_master_model.sv */
`timescale 1ns/100ps
module sss_master_model
   import sss_pkg::*;
(
   input  wire logic         clock_in,
   output logic [ADDR_W-1:0] bus_addr_out,
   output logic              bus_sel_out,
   output logic              cfg_irq_out,
   output logic              exec_out,
   output logic              link_ok_out
);
   initial begin
      bus_addr_out = 8'h00;
      bus_sel_out  = 1'b0;
      cfg_irq_out  = 1'b0;
      exec_out     = 1'b1;
      link_ok_out  = 1'b1;
   end
   // address held well past the interrupt so the slave sees a stable match
   task automatic send_cfg(input logic [ADDR_W-1:0] a);
      @(posedge clock_in) #1;
      bus_addr_out = a;
      bus_sel_out  = 1'b1;
      repeat (2) @(posedge clock_in) #1;
      cfg_irq_out = 1'b1;
      repeat (6) @(posedge clock_in) #1;
      cfg_irq_out = 1'b0;
      repeat (4) @(posedge clock_in) #1;
      bus_sel_out  = 1'b0;
      bus_addr_out = ~a;
   endtask
   task automatic set_mode(input logic e, input logic l);
      @(posedge clock_in) #1;
      exec_out    = e;
      link_ok_out = l;
   endtask
endmodule

/* File: test/sss_props.sv */
`timescale 1ns/100ps
module sss_props (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic BUS_SEL_IN,
   input wire logic FATAL_FAIL_IN,
   input wire logic POWER_FAIL_INTERRUPT_IN,
   input wire logic SELECTED_OUT,
   input wire logic REINIT_OUT,
   input wire logic READ_GOOD_OUT,
   input wire logic SCAN_ENABLE_OUT,
   input wire logic LED_RED_OUT,
   input wire logic LED_GREEN_OUT
);
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   a_sel_needs_bus: assert property (SELECTED_OUT |-> $past(BUS_SEL_IN, 2))
      else $error("selected without bus cycle");
   a_reinit_one_cycle: assert property (REINIT_OUT |=> !REINIT_OUT)
      else $error("reinit pulse too long");
   a_reinit_addressed: assert property (REINIT_OUT |-> $past(SELECTED_OUT) ||
      $past(SELECTED_OUT, 2) || $past(SELECTED_OUT, 3)) else $error("reinit without match");
   a_fatal_red_held: assert property ($rose(FATAL_FAIL_IN) |-> ##6 LED_RED_OUT[*8])
      else $error("fatal not steady red");
   a_pfi_red_held: assert property ($rose(POWER_FAIL_INTERRUPT_IN) |-> ##6 LED_RED_OUT[*8])
      else $error("power fail not steady red");
   a_red_excl_green: assert property (LED_RED_OUT |-> !LED_GREEN_OUT)
      else $error("red and green together");
   a_green_on_run: assert property ($rose(SCAN_ENABLE_OUT) |-> ##1 LED_GREEN_OUT)
      else $error("no green once running");
   a_quality_cleared: assert property (REINIT_OUT |-> ##2 !READ_GOOD_OUT)
      else $error("quality kept over reinit");
endmodule
bind sss_top sss_props u_sss_props (.CLOCK_IN, .RESET_N_IN, .BUS_SEL_IN, .FATAL_FAIL_IN,
   .POWER_FAIL_INTERRUPT_IN, .SELECTED_OUT, .REINIT_OUT, .READ_GOOD_OUT, .SCAN_ENABLE_OUT,
   .LED_RED_OUT, .LED_GREEN_OUT);
